/* common/pmd_pkg.sv */
// ==========================================================================
// address map and field constants for the paged memory decoder
package pmd_pkg;
  localparam int          ADDR_W         = 16;
  localparam int          PAGE_REG_W     = 8;
  localparam int          PAGE_BITS_MAX  = 4;  // up to 16 pages
  localparam int          MAIN_SEGS      = 8;
  localparam int          SEC_SEGS       = 4;
  // main flash: one 32K segment per page in 8000..ffff
  localparam logic [15:0] MAIN_BASE      = 16'h8000;
  localparam logic [15:0] MAIN_LAST      = 16'hffff;
  // secondary flash: four 8K segments at 0000..7fff, page independent
  localparam logic [15:0] SEC_BASE       = 16'h0000;
  localparam logic [15:0] SEC_SEG_SIZE   = 16'h2000;
  // sram: 8K in data space
  localparam logic [15:0] SRAM_BASE      = 16'h2000;
  localparam logic [15:0] SRAM_SIZE      = 16'h2000;
  // i/o register block: 256 locations, 40 implemented
  localparam logic [15:0] IO_BASE_RST    = 16'h0200;
  localparam logic [15:0] IO_SPAN        = 16'h0100;
  localparam logic [7:0]  IO_IMPL        = 8'h28;
  // space select register layout
  localparam int          SPC_MAIN_CODE  = 0;
  localparam int          SPC_MAIN_DATA  = 1;
  localparam int          SPC_SEC_CODE   = 2;
  localparam int          SPC_SEC_DATA   = 3;
  localparam logic [3:0]  SPC_RST        = 4'h6; // main data, secondary code
  // reset and idle values of the pin synchronisers and the page register
  localparam logic [15:0] ADDR_RST       = 16'h0000;
  localparam logic [3:0]  STRB_IDLE      = 4'hf;  // strobes inactive, latch enable low
  localparam logic [7:0]  PAGE_RST       = 8'h00;
endpackage

/* design/pmd_range_sel.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// one select: address inside [base, base+size), optional page compare
module pmd_range_sel #(
  parameter logic [15:0] BASE     = 16'h0000,
  parameter logic [16:0] SIZE     = 17'h02000,
  parameter int          PAGE_W   = 4,
  parameter logic [3:0]  PAGE_NUM = 4'h0,
  parameter bit          PAGED    = 1'b0
) (
  // address and page
  input  wire logic [15:0] addr,
  input  wire logic [3:0]  page,
  input  wire logic [3:0]  page_mask,
  // qualified access
  input  wire logic        access,
  output logic             sel
);
  wire logic [16:0] offs     = {1'b0, addr} - {1'b0, BASE};
  wire logic        in_range = (addr >= BASE) && (offs < SIZE);
  wire logic        page_ok  = !PAGED || ((page & page_mask) == (PAGE_NUM & page_mask));
  // combine range, page and strobe
  assign sel = in_range && page_ok && access;
endmodule
`default_nettype wire

/* design/pmd_decoder.sv */
`timescale 1ns/10ps
`default_nettype none

// timing: a settled bus level reaches the selects three clocks later,
// two clocks in the pin synchronisers and one in the output flops;
// a register write reaches the selects one clock after its write edge
module pmd_decoder #(
  parameter int PAGE_BITS = 3
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // processor bus, active-low strobes from off chip
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_rd_n,
  input  wire logic        cpu_wr_n,
  input  wire logic        cpu_fetch_n,
  input  wire logic        cpu_ale,
  // register writes from the i/o block logic
  input  wire logic        page_wr,
  input  wire logic [7:0]  page_wdata,
  input  wire logic        space_wr,
  input  wire logic [3:0]  space_wdata,
  input  wire logic        io_base_wr,
  input  wire logic [7:0]  io_base_wdata,
  // selects
  output logic [7:0]       main_flash_sel,
  output logic [3:0]       secondary_flash_sel,
  output logic             sram_select,
  output logic             io_block_sel,
  output logic             io_impl_hit,
  // state
  output logic [7:0]       page_register_q,
  output logic [3:0]       space_select_register_q,
  output logic [7:0]       spare_page_bits
);
  // ==========================================================================
  // pin synchronisers
  // every bus pin comes from outside this clock, so each bit passes two flops;
  // address and strobes share the path, so they stay aligned with each other
  logic [15:0] addr_m_q;  // first stage, read only by the second
  logic [15:0] addr_q;
  logic [3:0]  strb_m_q;  // {rd_n, wr_n, fetch_n, ale_n}, first stage
  logic [3:0]  strb_q;
  // two-stage capture; reset parks the strobes at their idle levels
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_m_q <= pmd_pkg::ADDR_RST;
      addr_q   <= pmd_pkg::ADDR_RST;
      strb_m_q <= pmd_pkg::STRB_IDLE;
      strb_q   <= pmd_pkg::STRB_IDLE;
    end else begin
      addr_m_q <= cpu_addr;
      addr_q   <= addr_m_q;
      strb_m_q <= {cpu_rd_n, cpu_wr_n, cpu_fetch_n, ~cpu_ale};
      strb_q   <= strb_m_q;
    end
  end
  // synchronised strobes, active high
  wire logic rd    = !strb_q[3];
  wire logic wr    = !strb_q[2];
  wire logic fetch = !strb_q[1];
  wire logic ale   = !strb_q[0];

  // ==========================================================================
  // registers
  // page register: low bits page the main flash, the rest are spare outputs
  logic [7:0] page_q;
  // space select: one bit per array and space, so an array may sit in both
  logic [3:0] space_q;
  // i/o base: bits 15:8 of the relocatable 256-location window
  logic [7:0] io_base_q;
  // page, space and i/o base registers; reset restores power-up map
  // a write lands on the edge that samples it, with no need for an idle bus
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      page_q    <= pmd_pkg::PAGE_RST;
      space_q   <= pmd_pkg::SPC_RST;
      io_base_q <= pmd_pkg::IO_BASE_RST[15:8];
    end else begin
      if (page_wr)    page_q    <= page_wdata;
      if (space_wr)   space_q   <= space_wdata;
      if (io_base_wr) io_base_q <= io_base_wdata;
    end
  end
  // register values for the processor to read back
  assign page_register_q         = page_q;
  assign space_select_register_q = space_q;

  // ==========================================================================
  // paging: low contiguous bits, at most four
  // a paging width over four is clamped, keeping at most 16 pages
  localparam int PB = (PAGE_BITS > pmd_pkg::PAGE_BITS_MAX) ? pmd_pkg::PAGE_BITS_MAX : PAGE_BITS;
  // ones from bit zero upward with no gap, so pages count in binary
  wire logic [3:0] page_mask = 4'((5'h01 << PB) - 5'h01);
  wire logic [3:0] page_val  = page_q[3:0] & page_mask;
  // spare bits: paging bits cleared, the upper bits pass unchanged
  wire logic [7:0] spare_mask = ~{4'h0, page_mask};
  assign spare_page_bits = page_q & spare_mask;

  // ==========================================================================
  // strobe qualification per space
  // the latch phase blanks every select so no block sees a half-formed address;
  // data space answers read or write, code space answers fetch
  wire logic data_acc = (rd || wr) && !ale;
  wire logic code_acc = fetch && !ale;
  // each array answers in the spaces that its register bits name
  wire logic main_acc = (space_q[pmd_pkg::SPC_MAIN_DATA] && data_acc)
                     || (space_q[pmd_pkg::SPC_MAIN_CODE] && code_acc);
  wire logic sec_acc  = (space_q[pmd_pkg::SPC_SEC_CODE] && code_acc)
                     || (space_q[pmd_pkg::SPC_SEC_DATA] && data_acc);

  // ==========================================================================
  // segment decoders
  wire logic [7:0] main_raw;
  wire logic [3:0] sec_raw;
  wire logic       sram_raw;
  wire logic       io_raw;
  // one range compare per segment
  genvar gi;
  generate
    // main flash: one 32K segment per page over the upper half
    for (gi = 0; gi < pmd_pkg::MAIN_SEGS; gi++) begin : g_main
      pmd_range_sel #(
        .BASE     (pmd_pkg::MAIN_BASE),
        .SIZE     (17'({1'b0, pmd_pkg::MAIN_LAST} - {1'b0, pmd_pkg::MAIN_BASE} + 17'h1)),
        .PAGE_NUM (4'(gi)),
        .PAGED    (1'b1)
      ) u_sel (
        .addr      (addr_q),
        .page      (page_val),
        .page_mask (page_mask),
        .access    (main_acc),
        .sel       (main_raw[gi])
      );
    end
    // secondary flash: four 8K segments in the lower half, any page
    for (gi = 0; gi < pmd_pkg::SEC_SEGS; gi++) begin : g_sec
      pmd_range_sel #(
        .BASE  (16'(pmd_pkg::SEC_BASE + 16'(gi) * pmd_pkg::SEC_SEG_SIZE)),
        .SIZE  ({1'b0, pmd_pkg::SEC_SEG_SIZE}),
        .PAGED (1'b0)
      ) u_sel (
        .addr      (addr_q),
        .page      (page_val),
        .page_mask (page_mask),
        .access    (sec_acc),
        .sel       (sec_raw[gi])
      );
    end
  endgenerate

  // sram: data space only, no page term
  pmd_range_sel #(
    .BASE  (pmd_pkg::SRAM_BASE),
    .SIZE  ({1'b0, pmd_pkg::SRAM_SIZE}),
    .PAGED (1'b0)
  ) u_sram (
    .addr      (addr_q),
    .page      (page_val),
    .page_mask (page_mask),
    .access    (data_acc),
    .sel       (sram_raw)
  );

  // i/o block: 256-location window at relocatable base, unpaged
  // no page term and no qualifier beyond the data strobe
  wire logic io_base_hit = (addr_q[15:8] == io_base_q);
  assign io_raw = io_base_hit && data_acc;

  // ==========================================================================
  // priority: i/o over sram over flash; nothing matched leaves all low
  // the sram overlaps secondary segment one and the i/o window may land on any
  // segment; when they share data space the i/o window takes the access, then the sram
  wire logic over_io   = io_raw;
  wire logic over_sram = io_raw || sram_raw;
  logic [7:0] main_d;
  logic [3:0] sec_d;
  logic       sram_d;
  logic       io_d;
  logic       impl_d;
  assign main_d = over_sram ? 8'h00 : main_raw;
  assign sec_d  = over_sram ? 4'h0  : sec_raw;
  assign sram_d = sram_raw && !over_io;
  assign io_d   = io_raw;
  // implemented flag: offset below the count of registers in use
  assign impl_d = io_raw && (addr_q[7:0] < pmd_pkg::IO_IMPL);

  // registered select outputs
  // held low through reset so no block sees a stray access
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_flash_sel      <= 8'h00;
      secondary_flash_sel <= 4'h0;
      sram_select         <= 1'b0;
      io_block_sel        <= 1'b0;
      io_impl_hit         <= 1'b0;
    end else begin
      main_flash_sel      <= main_d;
      secondary_flash_sel <= sec_d;
      sram_select         <= sram_d;
      io_block_sel        <= io_d;
      io_impl_hit         <= impl_d;
    end
  end
endmodule
`default_nettype wire

/* tb/pmd_decoder_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// ====================
// port checks for the paged decoder
module pmd_decoder_assertions #(parameter int PAGE_BITS = 3) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // processor bus
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_rd_n,
  input wire logic        cpu_wr_n,
  input wire logic        cpu_fetch_n,
  input wire logic        cpu_ale,
  // register writes
  input wire logic        page_wr,
  input wire logic [7:0]  page_wdata,
  input wire logic        space_wr,
  input wire logic [3:0]  space_wdata,
  input wire logic        io_base_wr,
  input wire logic [7:0]  io_base_wdata,
  // selects
  input wire logic [7:0]  main_flash_sel,
  input wire logic [3:0]  secondary_flash_sel,
  input wire logic        sram_select,
  input wire logic        io_block_sel,
  input wire logic        io_impl_hit,
  // state
  input wire logic [7:0]  page_register_q,
  input wire logic [3:0]  space_select_register_q,
  input wire logic [7:0]  spare_page_bits
);
  logic [7:0] io_base_q;
  wire [7:0]  pmask = 8'((1 << PAGE_BITS) - 1);
  wire        quiet = !cpu_ale && !page_wr && !space_wr && !io_base_wr;
  wire        dstb = !(cpu_rd_n && cpu_wr_n);
  wire [14:0] sels = {main_flash_sel, secondary_flash_sel, sram_select, io_block_sel, io_impl_hit};
  // shadow of the relocatable i/o base
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst) io_base_q <= pmd_pkg::IO_BASE_RST[15:8];
    else if (io_base_wr) io_base_q <= io_base_wdata;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // bus and registers steady long enough to pass the synchronisers
  sequence st;
    ($stable(cpu_addr) && $stable({cpu_rd_n, cpu_wr_n, cpu_fetch_n}) && quiet) [*4];
  endsequence
  a_main_data: assert property (
    st ##0 (cpu_addr[15] && dstb && space_select_register_q[1] && cpu_addr[15:8] != io_base_q)
    |-> main_flash_sel == 8'(1 << (page_register_q & pmask))) else $error("main select wrong");
  a_main_code_only: assert property (
    st ##0 (cpu_addr[15] && cpu_fetch_n && !space_select_register_q[1]) |-> main_flash_sel == 8'h00)
    else $error("main select outside its space");
  a_sec_fetch: assert property (
    st ##0 (!cpu_addr[15] && !cpu_fetch_n && !dstb && space_select_register_q[2])
    |-> secondary_flash_sel == 4'(1 << cpu_addr[14:13])) else $error("secondary select wrong");
  a_sram_data: assert property (
    st ##0 (cpu_addr[15:13] == 3'h1 && !cpu_rd_n && cpu_addr[15:8] != io_base_q)
    |-> sram_select && secondary_flash_sel == 4'h0) else $error("sram select missing");
  a_io_block: assert property (
    st ##0 (cpu_addr[15:8] == io_base_q && dstb)
    |-> io_block_sel && io_impl_hit == (cpu_addr[7:0] < pmd_pkg::IO_IMPL))
    else $error("io select wrong");
  a_no_strobe: assert property (
    st ##0 (!dstb && cpu_fetch_n) |-> sels == 15'h0000) else $error("select without strobe");
  a_code_no_data: assert property (
    st ##0 !dstb |-> !sram_select && !io_block_sel) else $error("data select on fetch");
  a_spare_bits: assert property (
    spare_page_bits == (page_register_q & ~pmask)) else $error("spare page bits wrong");
  a_reset_place: assert property (
    $fell(sys_rst) |-> space_select_register_q == pmd_pkg::SPC_RST
    && page_register_q == pmd_pkg::PAGE_RST)
    else $error("reset placement wrong");
endmodule
`default_nettype wire

/* tb/pmd_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ====================
// processor bus: latch phase, then one strobe held until the next request
module pmd_cpu_model (
  // request from the bench
  input  wire logic        ref_clk,
  input  wire logic        go,
  input  wire logic [1:0]  kind,
  input  wire logic [15:0] addr,
  // bus pins
  output var logic [15:0]  cpu_addr,
  output var logic         cpu_ale,
  output var logic         cpu_rd_n,
  output var logic         cpu_wr_n,
  output var logic         cpu_fetch_n
);
  initial {cpu_addr, cpu_ale, cpu_rd_n, cpu_wr_n, cpu_fetch_n} = 20'h00007;
  // kinds: 1 fetch, 2 read, 3 write
  always @(negedge ref_clk) begin
    cpu_ale <= go;
    if (go) begin
      cpu_addr <= addr;
      {cpu_rd_n, cpu_wr_n, cpu_fetch_n} <= 3'h7;
    end else if (cpu_ale) begin
      {cpu_rd_n, cpu_wr_n, cpu_fetch_n} <= {kind != 2'h2, kind != 2'h3, kind != 2'h1};
    end
  end
endmodule
`default_nettype wire

/* tb/pmd_decoder_bench.sv */
`timescale 1ns/10ps
`default_nettype none
// ====================
// self-checking bench for the paged decoder
module pmd_decoder_bench;
  typedef struct packed {logic [3:0] sp; logic [7:0] pg; logic [1:0] k;
    logic [15:0] a; logic [14:0] e;} pmd_row_s;
  logic        ref_clk = 0, sys_rst = 1, go = 0, page_wr = 0, space_wr = 0, io_base_wr = 0;
  logic [7:0]  page_wdata = 0, io_base_wdata = 0, main_flash_sel, page_register_q, spare_page_bits;
  logic [3:0]  space_wdata = 0, secondary_flash_sel, space_select_register_q;
  logic [1:0]  kind = 0;
  logic [15:0] addr = 0, cpu_addr;
  logic        cpu_ale, cpu_rd_n, cpu_wr_n, cpu_fetch_n, sram_select, io_block_sel, io_impl_hit;
  int          n_fail = 0, compares = 0;
  wire [14:0]  sels = {main_flash_sel, secondary_flash_sel, sram_select, io_block_sel, io_impl_hit};
  // space, page, kind, address, expected {main, secondary, sram, io, impl}
  pmd_row_s rows [13] = '{'{4'h6, 8'h01, 2'h2, 16'h8000, 15'h0100},
    '{4'h6, 8'hff, 2'h3, 16'hffff, 15'h4000}, '{4'h6, 8'h00, 2'h1, 16'h8000, 15'h0000},
    '{4'h6, 8'h05, 2'h1, 16'h6000, 15'h0040}, '{4'h6, 8'h03, 2'h1, 16'h0000, 15'h0008},
    '{4'h6, 8'h00, 2'h2, 16'h0100, 15'h0000}, '{4'h6, 8'h09, 2'h2, 16'h2000, 15'h0004},
    '{4'h6, 8'h00, 2'h1, 16'h3fff, 15'h0010}, '{4'h6, 8'h00, 2'h2, 16'h0227, 15'h0003},
    '{4'h1, 8'h02, 2'h1, 16'h9000, 15'h0200}, '{4'h1, 8'h02, 2'h2, 16'h9000, 15'h0000},
    '{4'h8, 8'h00, 2'h2, 16'h4000, 15'h0020}, '{4'h8, 8'h00, 2'h2, 16'h2000, 15'h0004}};
  // processor bus partner
  pmd_cpu_model cpu (
    .ref_clk     (ref_clk),
    .go          (go),
    .kind        (kind),
    .addr        (addr),
    .cpu_addr    (cpu_addr),
    .cpu_ale     (cpu_ale),
    .cpu_rd_n    (cpu_rd_n),
    .cpu_wr_n    (cpu_wr_n),
    .cpu_fetch_n (cpu_fetch_n)
  );
  // decoder under test
  pmd_decoder #(.PAGE_BITS(3)) dut (
    .ref_clk                 (ref_clk),
    .sys_rst                 (sys_rst),
    .cpu_addr                (cpu_addr),
    .cpu_rd_n                (cpu_rd_n),
    .cpu_wr_n                (cpu_wr_n),
    .cpu_fetch_n             (cpu_fetch_n),
    .cpu_ale                 (cpu_ale),
    .page_wr                 (page_wr),
    .page_wdata              (page_wdata),
    .space_wr                (space_wr),
    .space_wdata             (space_wdata),
    .io_base_wr              (io_base_wr),
    .io_base_wdata           (io_base_wdata),
    .main_flash_sel          (main_flash_sel),
    .secondary_flash_sel     (secondary_flash_sel),
    .sram_select             (sram_select),
    .io_block_sel            (io_block_sel),
    .io_impl_hit             (io_impl_hit),
    .page_register_q         (page_register_q),
    .space_select_register_q (space_select_register_q),
    .spare_page_bits         (spare_page_bits)
  );
  initial forever #2.5 ref_clk = ~ref_clk;
  task chk(input logic [14:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task wreg(input logic [3:0] sp, input logic [7:0] pg);
    @(negedge ref_clk);
    {space_wr, space_wdata, page_wr, page_wdata} = {1'b1, sp, 1'b1, pg}; // low bits page
    @(negedge ref_clk);
    {space_wr, page_wr} = 2'h0;
  endtask
  task bus(input logic [1:0] k, input logic [15:0] a);
    @(negedge ref_clk);
    {go, kind, addr} <= {1'b1, k, a};
    @(negedge ref_clk);
    go <= 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask
  task end_of_test;
    $display("compares %0d, n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // table rows, then relocated i/o, spare bits and a second reset
  initial begin
    repeat (8) @(negedge ref_clk);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      wreg(rows[i].sp, rows[i].pg);
      bus(rows[i].k, rows[i].a);
      chk(sels, rows[i].e);
    end
    @(negedge ref_clk);
    {io_base_wr, io_base_wdata} = {1'b1, 8'h50};
    @(negedge ref_clk);
    io_base_wr = 1'b0;
    bus(2'h3, 16'h5028);
    chk(sels, 15'h0002);
    wreg(4'h1, 8'hf6);
    chk({7'h00, spare_page_bits}, 15'h00f0);
    chk({7'h00, page_register_q}, 15'h00f6);
    chk({11'h000, space_select_register_q}, 15'h0001);
    sys_rst = 1'b1;
    @(negedge ref_clk);
    sys_rst = 1'b0;
    chk({11'h000, space_select_register_q}, {11'h000, pmd_pkg::SPC_RST});
    chk({7'h00, page_register_q}, 15'h0000);
    bus(2'h2, 16'h8000);
    chk(sels, 15'h0080);
    end_of_test;
  end
  // watchdog well past the expected run
  initial begin
    #20000;
    n_fail++;
    end_of_test;
  end
endmodule
bind pmd_decoder pmd_decoder_assertions #(.PAGE_BITS(PAGE_BITS)) chk_i (
  .ref_clk                 (ref_clk),
  .sys_rst                 (sys_rst),
  .cpu_addr                (cpu_addr),
  .cpu_rd_n                (cpu_rd_n),
  .cpu_wr_n                (cpu_wr_n),
  .cpu_fetch_n             (cpu_fetch_n),
  .cpu_ale                 (cpu_ale),
  .page_wr                 (page_wr),
  .page_wdata              (page_wdata),
  .space_wr                (space_wr),
  .space_wdata             (space_wdata),
  .io_base_wr              (io_base_wr),
  .io_base_wdata           (io_base_wdata),
  .main_flash_sel          (main_flash_sel),
  .secondary_flash_sel     (secondary_flash_sel),
  .sram_select             (sram_select),
  .io_block_sel            (io_block_sel),
  .io_impl_hit             (io_impl_hit),
  .page_register_q         (page_register_q),
  .space_select_register_q (space_select_register_q),
  .spare_page_bits         (spare_page_bits)
);
`default_nettype wire
